// >>> design/sac_params.svh
// sar converter control constants: register offsets, fields, resets, timing
// assumes inclusion by bare name from design files
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// ****************
// register offsets
// ****************
`define SAC_ADDR_CONTROL     8'hAA
`define SAC_ADDR_CONFIG      8'hAB
`define SAC_ADDR_CHANNEL     8'hAC
`define SAC_ADDR_RESULT      8'hBE
// ****************
// reset values
// ****************
`define SAC_RST_CONTROL      8'h00
`define SAC_RST_CONFIG       8'hF8
`define SAC_RST_CHANNEL      8'h00
// ****************
// field positions
// ****************
`define SAC_BIT_ENABLE       7
`define SAC_BIT_TRACK_MODE   6
`define SAC_BIT_DONE         5
`define SAC_BIT_BUSY         4
`define SAC_DIV_HI           7
`define SAC_DIV_LO           3
`define SAC_GAIN_HI          1
`define SAC_GAIN_LO          0
`define SAC_SRC_HI           3
`define SAC_SRC_LO           1
`define SAC_CFG_WMASK        8'hFB
`define SAC_CTL_WMASK        8'hEE
`define SAC_CHN_WMASK        8'h07
// ****************
// timing in sar clocks
// ****************
`define SAC_TRACK_CLKS       2'd3
`define SAC_CONV_CLKS        4'd8
`endif

// >>> design/sac_pkg.sv
// sar converter control types
// assumes sac_params.svh constants alongside
package sac_pkg;
  typedef enum logic [1:0] {SAC_IDLE, SAC_TRACK, SAC_CONV} sac_state_t;
  typedef enum logic [2:0] {
    SAC_SRC_SW     = 3'h0,
    SAC_SRC_TMR3   = 3'h1,
    SAC_SRC_PIN    = 3'h2,
    SAC_SRC_TMR2   = 3'h3
  } sac_src_t;
endpackage

// >>> design/sac_sar_tick.sv
// sar clock divider: one tick every (divider+1) system clocks
// assumes divider value held stable by software while converting
`timescale 1ns/10ps
module sac_sar_tick import sac_pkg::*; (
  input  wire logic       clk,      // system clock
  input  wire logic       rst,      // sync reset, active high
  input  wire logic       run,      // counting allowed
  input  wire logic [4:0] divider,  // divide by divider+1
  output logic            tick      // one-cycle pulse per sar clock
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  assign tick = tick_r;
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = 5'h0_0;
    end else if (cnt_r >= divider) begin
      cnt_nxt  = 5'h0_0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 5'h0_1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= 5'h0_0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// >>> design/sac_ctrl.sv
// sar converter control: registers, triggers, track and convert sequence
// assumes a single-cycle register port from the core and an analog
// comparator answering each trial bit within one sar clock
//
// Behaviour
// - sar clock is system clock divided by divider field plus one
// - gain field 00 half, 01 unity, 10 two, 11 four
// - config bit 2 reads zero, writes ignored
// - three-bit channel field picks one of eight inputs
// - channel register upper five bits read zero, writes ignored
// - enable zero means shutdown; one means active and accepting starts
// - track mode clear tracks continuously except during conversion
// - done flag sets on busy fall; only software clears it
// - busy reads one while tracking after a start or converting, zero otherwise
// - writing busy one starts only with source 000; zero no effect
// - source 000 busy, 001 timer3, 010 pin rise, 011 timer2, 1xx companion
// - low-power mode non-pin sources track three sar clocks first
// - low-power pin mode tracks while pin low, converts on rise
// - control bit 0 reads zero, writes ignored
// - conversion takes eight sar clocks before result and busy fall
// - result is unsigned eight-bit code, saturating at all ones
// - busy fall raises interrupt request when enabled
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_ctrl import sac_pkg::*; (
  input  wire logic       clk,              // system clock
  input  wire logic       rst,              // sync reset, active high
  input  wire logic [7:0] reg_addr,         // register address
  input  wire logic       reg_wr,           // write strobe
  input  wire logic [7:0] reg_wdata,        // write data
  output logic      [7:0] reg_rdata,        // read data, one cycle later
  input  wire logic       timer3_overflow,  // timer 3 overflow pulse
  input  wire logic       timer2_overflow,  // timer 2 overflow pulse
  input  wire logic       companion_converter_busy, // companion busy-write pulse
  input  wire logic       external_convert_start,   // async pin
  input  wire logic       irq_enable,       // interrupt enable from core
  input  wire logic       cmp_high,         // comparator: input at or above trial
  output logic      [2:0] channel_select,   // mux select
  output logic      [1:0] pga_gain_select,  // amplifier gain code
  output logic            analog_power,     // converter powered
  output logic            track_en,         // track-and-hold tracking
  output logic      [7:0] sar_trial,        // trial code to dac
  output logic            irq_req           // interrupt request pulse
);
  // ****************
  // registers
  // ****************
  logic [7:0]  ctl_r, ctl_nxt;
  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  chn_r, chn_nxt;
  logic [7:0]  res_r, res_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        pin_s1_r, pin_s2_r, pin_s3_r;
  sac_state_t  st_r, st_nxt;
  logic [1:0]  trk_r, trk_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sar_r, sar_nxt;
  logic        irq_r, irq_nxt;
  logic        trk_out_r, trk_out_nxt;
  logic        tick;
  logic        enabled, lp_mode, busy, start, pin_rise, busy_fall;
  logic [2:0]  src;
  assign enabled   = ctl_r[`SAC_BIT_ENABLE];
  assign lp_mode   = ctl_r[`SAC_BIT_TRACK_MODE];
  assign src       = ctl_r[`SAC_SRC_HI:`SAC_SRC_LO];
  assign busy      = (st_r != SAC_IDLE);
  assign pin_rise  = pin_s2_r && !pin_s3_r;
  assign busy_fall = (st_r == SAC_CONV) && tick && (bit_r == `SAC_CONV_CLKS - 4'd1);
  // ****************
  // sar clock divider
  // ****************
  sac_sar_tick u_tick (
    .clk     (clk),
    .rst     (rst),
    .run     (busy),
    .divider (cfg_r[`SAC_DIV_HI:`SAC_DIV_LO]),
    .tick    (tick)
  );
  // ****************
  // start trigger selection
  // ****************
  always_comb begin
    start = 1'b0;
    if (src[2]) begin
      start = companion_converter_busy;
    end else begin
      unique case (sac_src_t'(src))
        SAC_SRC_SW:   start = reg_wr && reg_addr == `SAC_ADDR_CONTROL
                              && reg_wdata[`SAC_BIT_BUSY];
        SAC_SRC_TMR3: start = timer3_overflow;
        SAC_SRC_PIN:  start = pin_rise;
        SAC_SRC_TMR2: start = timer2_overflow;
      endcase
    end
  end
  // ****************
  // sequence
  // ****************
  always_comb begin
    st_nxt  = st_r;
    trk_nxt = trk_r;
    bit_nxt = bit_r;
    sar_nxt = sar_r;
    res_nxt = res_r;
    irq_nxt = 1'b0;
    unique case (st_r)
      SAC_IDLE: begin
        if (enabled && start) begin
          trk_nxt = 2'd0;
          bit_nxt = 4'd0;
          sar_nxt = 8'h80;
          if (lp_mode && src != SAC_SRC_PIN) st_nxt = SAC_TRACK;
          else st_nxt = SAC_CONV;
        end
      end
      SAC_TRACK: begin
        if (tick) begin
          trk_nxt = trk_r + 2'd1;
          if (trk_r == `SAC_TRACK_CLKS - 2'd1) st_nxt = SAC_CONV;
        end
      end
      SAC_CONV: begin
        if (tick) begin
          // binary search; unsigned code saturates at all ones by nature
          sar_nxt = sar_r;
          if (!cmp_high) sar_nxt = sar_r & ~(8'h80 >> bit_r);
          if (bit_r != 4'd7) sar_nxt = sar_nxt | (8'h40 >> bit_r);
          bit_nxt = bit_r + 4'd1;
          if (busy_fall) begin
            st_nxt  = SAC_IDLE;
            res_nxt = sar_nxt;
            irq_nxt = irq_enable;
          end
        end
      end
      default: st_nxt = SAC_IDLE;
    endcase
    if (!enabled) st_nxt = SAC_IDLE;
  end
  // ****************
  // register file
  // ****************
  always_comb begin
    ctl_nxt   = ctl_r;
    cfg_nxt   = cfg_r;
    chn_nxt   = chn_r;
    rdata_nxt = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        `SAC_ADDR_CONTROL: ctl_nxt = reg_wdata & `SAC_CTL_WMASK;
        `SAC_ADDR_CONFIG:  cfg_nxt = reg_wdata & `SAC_CFG_WMASK;
        `SAC_ADDR_CHANNEL: chn_nxt = reg_wdata & `SAC_CHN_WMASK;
        default: ;
      endcase
      // write of one to done is kept; zero clears; busy bit not stored
      if (reg_addr == `SAC_ADDR_CONTROL) ctl_nxt[`SAC_BIT_BUSY] = 1'b0;
    end
    if (busy_fall && enabled) ctl_nxt[`SAC_BIT_DONE] = 1'b1;
    unique case (reg_addr)
      `SAC_ADDR_CONTROL: begin
        rdata_nxt = ctl_r;
        rdata_nxt[`SAC_BIT_BUSY] = busy;
      end
      `SAC_ADDR_CONFIG:  rdata_nxt = cfg_r;
      `SAC_ADDR_CHANNEL: rdata_nxt = chn_r;
      `SAC_ADDR_RESULT:  rdata_nxt = res_r;
      default:           rdata_nxt = 8'h00;
    endcase
    trk_out_nxt = enabled && (lp_mode ? (src == SAC_SRC_PIN ? !pin_s2_r
                 : st_nxt == SAC_TRACK) : st_nxt != SAC_CONV);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r     <= `SAC_RST_CONTROL;
      cfg_r     <= `SAC_RST_CONFIG;
      chn_r     <= `SAC_RST_CHANNEL;
      res_r     <= 8'h00;
      rdata_r   <= 8'h00;
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      pin_s3_r  <= 1'b0;
      st_r      <= SAC_IDLE;
      trk_r     <= 2'd0;
      bit_r     <= 4'd0;
      sar_r     <= 8'h00;
      irq_r     <= 1'b0;
      trk_out_r <= 1'b0;
    end else begin
      ctl_r     <= ctl_nxt;
      cfg_r     <= cfg_nxt;
      chn_r     <= chn_nxt;
      res_r     <= res_nxt;
      rdata_r   <= rdata_nxt;
      pin_s1_r  <= external_convert_start;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      st_r      <= st_nxt;
      trk_r     <= trk_nxt;
      bit_r     <= bit_nxt;
      sar_r     <= sar_nxt;
      irq_r     <= irq_nxt;
      trk_out_r <= trk_out_nxt;
    end
  end
  assign reg_rdata       = rdata_r;
  assign channel_select  = chn_r[2:0];
  assign pga_gain_select = cfg_r[`SAC_GAIN_HI:`SAC_GAIN_LO];
  assign analog_power    = ctl_r[`SAC_BIT_ENABLE];
  assign track_en        = trk_out_r;
  assign sar_trial       = sar_r;
  assign irq_req         = irq_r;
  // ****************
  // checks
  // ****************
  chk_done_on_fall: assert property (@(posedge clk) disable iff (rst)
    busy_fall && enabled |=> ctl_r[`SAC_BIT_DONE]) else $error("done flag not set");
  chk_result_same: assert property (@(posedge clk) disable iff (rst)
    busy_fall && enabled |=> res_r == $past(sar_nxt) && st_r == SAC_IDLE)
    else $error("result late");
  chk_cfg_bit2: assert property (@(posedge clk) disable iff (rst)
    cfg_r[2] == 1'b0) else $error("config bit 2 set");
  chk_chn_upper: assert property (@(posedge clk) disable iff (rst)
    chn_r[7:3] == 5'h0_0) else $error("channel upper bits set");
  chk_ctl_bit0: assert property (@(posedge clk) disable iff (rst)
    ctl_r[0] == 1'b0) else $error("control bit 0 set");
  chk_disabled_idle: assert property (@(posedge clk) disable iff (rst)
    !enabled |=> st_r == SAC_IDLE) else $error("runs while disabled");
  chk_no_restart: assert property (@(posedge clk) disable iff (rst)
    st_r == SAC_CONV && !tick && enabled |=> st_r == SAC_CONV && $stable(bit_r))
    else $error("conversion disturbed");
  chk_busy_write: assert property (@(posedge clk) disable iff (rst)
    st_r == SAC_IDLE && enabled && src != 3'h0 && !src[2] && reg_wr
    && reg_addr == `SAC_ADDR_CONTROL && !timer3_overflow && !timer2_overflow
    && !pin_rise |=> st_r == SAC_IDLE) else $error("busy write started");
  chk_track_to_conv: assert property (@(posedge clk) disable iff (rst)
    st_r == SAC_TRACK && tick && trk_r == 2'd2 && enabled |=> st_r == SAC_CONV)
    else $error("track length wrong");
  chk_irq_pulse: assert property (@(posedge clk) disable iff (rst)
    irq_r |-> $past(busy_fall) && $past(irq_enable)) else $error("stray irq");
  cov_conv: cover property (@(posedge clk) disable iff (rst) busy_fall);
  cov_lp: cover property (@(posedge clk) disable iff (rst) st_r == SAC_TRACK && tick);
  cov_pin: cover property (@(posedge clk) disable iff (rst) pin_rise && start);
endmodule

// >>> dv/sac_analog_model.sv
// analog side stand-in: track-and-hold plus comparator for the sar loop
// assumes the bench sets code as the input level in lsbs
`timescale 1ns/10ps
module sac_analog_model (
  input  wire logic       clk,      // system clock
  input  wire logic [7:0] code,     // input level in lsbs
  input  wire logic       powered,  // converter powered
  input  wire logic       tracking, // track-and-hold tracking
  input  wire logic [7:0] trial,    // trial code
  output logic            cmp_high  // held input at or above trial
);
  logic [7:0] held_r;
  logic       junk_r = 1'b0;
  always_ff @(posedge clk) begin
    junk_r <= ~junk_r;
    if (powered && tracking) begin
      held_r <= code;
    end
  end
  // unpowered comparator wanders rather than settling
  assign cmp_high = powered ? (held_r >= trial) : junk_r;
endmodule

// >>> dv/sar_adc8_control_bench.sv
// self-checking bench: register access, start sources, timing, result, flags
// assumes sac_ctrl with the analog model on its comparator side
`timescale 1ns/10ps
`include "sac_params.svh"
module sar_adc8_control_bench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, sar_trial, code = 8'h00, d, ctl;
  logic       timer3_overflow = 1'b0;
  logic       timer2_overflow = 1'b0;
  logic       companion_converter_busy = 1'b0;
  logic       external_convert_start = 1'b0;
  logic       irq_enable = 1'b0;
  logic       cmp_high, analog_power, track_en, irq_req, lp;
  logic [2:0] channel_select, src;
  logic [1:0] pga_gain_select;
  logic [4:0] dv;
  logic [15:0] seed = 16'd37620;
  logic [2:0] srcs [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd7};
  int         n_errors = 0, comparisons = 0, cycles = 0, irq_cnt = 0, icnt, n, lo;

  sac_ctrl dut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .timer3_overflow,
    .timer2_overflow, .companion_converter_busy, .external_convert_start, .irq_enable,
    .cmp_high, .channel_select, .pga_gain_select, .analog_power, .track_en, .sar_trial,
    .irq_req);
  sac_analog_model ana (.clk, .code, .powered(analog_power), .tracking(track_en),
    .trial(sar_trial), .cmp_high);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (irq_req === 1'b1) irq_cnt++;
    if (cycles == 5000) begin
      n_errors++;
      $display("MISMATCH t=%0t run too long", $time);
      conclude();
    end
  end

  // ****
  // helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_span(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t took %0d cycles, want %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic fire(input logic [2:0] s, input logic [7:0] c);
    if (s == 3'd0) wr(`SAC_ADDR_CONTROL, c | 8'h10);
    else if (s == 3'd2) begin
      @(negedge clk);
      external_convert_start = 1'b1;
    end else begin
      @(negedge clk);
      timer3_overflow = (s == 3'd1);
      timer2_overflow = (s == 3'd3);
      companion_converter_busy = s[2];
      @(negedge clk);
      {timer3_overflow, timer2_overflow, companion_converter_busy} = 3'b000;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****
  // sequence
  // ****
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(`SAC_ADDR_CONTROL, d); check(d, `SAC_RST_CONTROL, "ctl reset");
    rd(`SAC_ADDR_CONFIG, d); check(d, `SAC_RST_CONFIG, "cfg reset");
    rd(`SAC_ADDR_CHANNEL, d); check(d, `SAC_RST_CHANNEL, "chn reset");
    wr(`SAC_ADDR_CONFIG, 8'hFF); rd(`SAC_ADDR_CONFIG, d); check(d, 8'hFB, "cfg");
    check({6'h00, pga_gain_select}, 8'h03, "gain pins");
    wr(`SAC_ADDR_CHANNEL, 8'hFE); rd(`SAC_ADDR_CHANNEL, d); check(d, 8'h06, "chn");
    check({5'h00, channel_select}, 8'h06, "chn pins");
    wr(`SAC_ADDR_CONTROL, 8'hEF); rd(`SAC_ADDR_CONTROL, d); check(d, 8'hEE, "ctl");
    wr(`SAC_ADDR_CONTROL, 8'h10); repeat (40) @(negedge clk);
    rd(`SAC_ADDR_CONTROL, d); check(d, 8'h00, "start when off");
    wr(`SAC_ADDR_CONTROL, 8'h82); wr(`SAC_ADDR_CONTROL, 8'h92); repeat (40) @(negedge clk);
    rd(`SAC_ADDR_CONTROL, d); check(d, 8'h82, "busy write, src 1");
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      src = srcs[k];
      dv = {3'b000, seed[1:0]};
      lp = seed[2];
      irq_enable = seed[3];
      code = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : seed[15:8];
      wr(`SAC_ADDR_CONFIG, {dv, 1'b0, seed[5:4]});
      wr(`SAC_ADDR_CHANNEL, {5'h00, seed[7:5]});
      ctl = {1'b1, lp, 2'b00, src, 1'b0};
      wr(`SAC_ADDR_CONTROL, ctl);
      rd(`SAC_ADDR_CONTROL, d); check(d, ctl, "done cleared");
      repeat (8) @(negedge clk);
      icnt = irq_cnt;
      fire(src, ctl);
      n = 0;
      if (src != 3'd2) begin
        fire(src, ctl);
        n = 2;
      end else begin
        // pin edge needs synchroniser plus edge flop before busy shows
        repeat (4) @(negedge clk);
      end
      do begin
        rd(`SAC_ADDR_CONTROL, d);
        n += 2;
      end while (d[`SAC_BIT_BUSY] === 1'b1 && n < 400);
      check(d, ctl | 8'h20, "ctl after");
      lo = (lp ? 11 : 8) * (int'(dv) + 1);
      if (src != 3'd2) check_span(n, lo, lo + 6);
      rd(`SAC_ADDR_RESULT, d); check(d, code, "result");
      check(8'(irq_cnt - icnt), {7'h00, irq_enable}, "irq count");
      external_convert_start = 1'b0;
      $display("test %0d done src %0d lp %0d", k, src, lp);
    end
    conclude();
  end
endmodule
